// file: mwiu_unpacker.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------
// mixed-width instruction unpacker
// ---------------------------------------------------------------------
// How it works
// RULE_01: 16-bit and 32-bit instructions may follow in any mix, unpadded.
// RULE_02: a word holds a long, two shorts, or any pairing of halves.
// RULE_03: a long immediate is unpacked exactly like a long instruction.
// RULE_04: the pc of the next instruction is worked out from each length.
// RULE_05: the opcode half of a long instruction is the first half fetched.
// RULE_06: little-endian memory holds the upper half at the lower address.
// RULE_07: little-endian long at N is bytes 2,3,0,1 at N..N+3.
// RULE_08: little-endian is the default and the only mode that swaps.
// RULE_09: big-endian takes bytes most significant first, with no swap.
// RULE_10: little-endian shorts sit in program order, low byte first.
// RULE_11: big-endian shorts sit in program order, high byte first.
// RULE_12: a long after a short starts at the next halfword address.
// RULE_13: fields are decoded only from the fully rebuilt word.
// RULE_14: a leftover half is kept and joined to the next fetched word.
module mwiu_unpacker (
  input  wire logic                         clk_in,
  input  wire logic                         srst_in,
  // stream control from the core
  input  wire logic                         big_endian_in,
  input  wire logic                         restart_in,
  input  wire logic [mwiu_pkg::ADDR_W-1:0]  restart_pc_in,
  input  wire logic                         limm_follows_in,
  // instruction memory side
  input  wire logic                         fetch_valid_in,
  output logic                              fetch_ready_out,
  input  wire logic [mwiu_pkg::WORD_W-1:0]  fetch_word_in,
  // decoder side
  output logic                              instr_valid_out,
  input  wire logic                         instr_ready_in,
  output logic      [mwiu_pkg::WORD_W-1:0]  instr_word_out,
  output logic      [mwiu_pkg::ADDR_W-1:0]  instr_pc_out,
  output logic                              instr_short_out,
  output logic                              instr_limm_out
);
  import mwiu_pkg::*;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    MWIU_ST_IDLE,
    MWIU_ST_RUN
  } mwiu_state_e;

  mwiu_state_e         state_r;
  logic                big_r;
  logic [HALF_W-1:0]   half_r [2];  // halves of the word being worked
  logic [1:0]          hcnt_r;      // halves held (0..2)
  logic [HALF_W-1:0]   part_r;      // opcode half waiting for its tail
  logic                part_v_r;
  logic                limm_pend_r;
  logic                kind_limm_r;
  logic [ADDR_W-1:0]   pc_r;
  logic [ADDR_W-1:0]   part_pc_r;
  logic                skip_r;      // restart on an odd halfword
  logic                fready_r;    // fetch ready, kept in a flop

  // output staging registers
  logic                out_v_r;
  logic [WORD_W-1:0]   out_w_r;
  logic [ADDR_W-1:0]   out_pc_r;
  logic                out_s_r;
  logic                out_l_r;

  mwiu_stream_if       ent_if ();

  logic [HALF_W-1:0]   h_lo;
  logic [HALF_W-1:0]   h_hi;
  logic [HALF_W-1:0]   cur_h;
  logic                cur_long;
  logic                emit;
  logic                take_word;
  logic                half_done;
  logic                fifo_rd_v;
  logic [ENTRY_W-1:0]  fifo_rd_d;
  mwiu_entry_s         fifo_ent;

  // -------------------------------------------------------------------
  // halfword extraction
  // -------------------------------------------------------------------
  // the bus word carries byte N in bits 7:0; in big-endian the halfword at
  // the lower address is its own high byte first, so bytes are swapped.
  always_comb begin
    if (big_r) begin
      h_lo = {fetch_word_in[7:0],   fetch_word_in[15:8]};   // RULE_11
      h_hi = {fetch_word_in[23:16], fetch_word_in[31:24]};  // RULE_09
    end else begin
      h_lo = fetch_word_in[15:0];                           // RULE_10
      h_hi = fetch_word_in[31:16];                          // RULE_07
    end
  end

  // the half at the lower address is always handled first
  assign cur_h     = half_r[0];                             // RULE_05
  // a pending long immediate is built whatever its bits look like
  assign cur_long  = limm_pend_r ||
                     (cur_h[OPC_MSB:OPC_LSB] < OPC_SHORT_MIN);
  // new word only once both held halves are used
  assign take_word = fready_r && (state_r == MWIU_ST_RUN);
  assign fetch_ready_out = fready_r;
  // a short, or the tail of a long, produces an entry this cycle
  assign emit = (hcnt_r != 2'd0) && ent_if.ready &&
                (part_v_r || !cur_long) && !skip_r;      // RULE_01
  // the half at the head is used up this cycle
  assign half_done = skip_r || emit || (!part_v_r && cur_long);

  // -------------------------------------------------------------------
  // mode capture, held while a stream runs
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      big_r   <= BIG_END_RST;                               // RULE_08
      state_r <= MWIU_ST_IDLE;
    end else if (restart_in) begin
      big_r   <= big_endian_in;
      state_r <= MWIU_ST_RUN;
    end
  end

  // -------------------------------------------------------------------
  // halfword buffer: hold the two halves of one fetched word until both are used
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in || restart_in) begin
      hcnt_r    <= 2'd0;
      half_r[0] <= '0;
      half_r[1] <= '0;
      skip_r    <= 1'b0;
    end else if (take_word && fetch_valid_in) begin
      half_r[0] <= h_lo;                                    // RULE_06
      half_r[1] <= h_hi;
      hcnt_r    <= 2'd2;
      skip_r    <= pc_r[1];  // odd restart drops the lower half
    end else if (hcnt_r != 2'd0 &&
                 (skip_r || emit || (!part_v_r && cur_long))) begin
      half_r[0] <= half_r[1];                               // RULE_14
      hcnt_r    <= hcnt_r - 2'd1;
      skip_r    <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // fetch ready
  // -------------------------------------------------------------------
  // tracks hcnt_r reaching zero on the same edge, so the port is a flop
  // and no combinational path runs from the buffer out to memory
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fready_r <= 1'b0;
    end else if (restart_in) begin
      fready_r <= 1'b1;
    end else if (take_word && fetch_valid_in) begin
      fready_r <= 1'b0;                                     // RULE_14
    end else if (hcnt_r != 2'd0 && half_done) begin
      fready_r <= (hcnt_r == 2'd1);
    end
  end

  // -------------------------------------------------------------------
  // long instruction assembly
  // -------------------------------------------------------------------
  // the opcode half is parked until the trailing half arrives, possibly
  // from the next fetched word (RULE_02 covers every split).
  always_ff @(posedge clk_in) begin
    if (srst_in || restart_in) begin
      part_v_r    <= 1'b0;
      part_r      <= '0;
      part_pc_r   <= PC_RST;
      kind_limm_r <= 1'b0;
    end else if (hcnt_r != 2'd0 && !skip_r) begin
      if (!part_v_r && cur_long) begin
        part_r      <= cur_h;                               // RULE_02
        part_pc_r   <= pc_r;                                // RULE_12
        part_v_r    <= 1'b1;
        kind_limm_r <= limm_pend_r;                         // RULE_03
      end else if (emit && part_v_r) begin
        part_v_r    <= 1'b0;
      end
    end
  end

  // long immediate flag from the decoder: the next long slot is data
  always_ff @(posedge clk_in) begin
    if (srst_in || restart_in) begin
      limm_pend_r <= 1'b0;
    end else if (limm_follows_in) begin
      limm_pend_r <= 1'b1;  // set wins over the consuming clear
    end else if (emit && part_v_r && kind_limm_r) begin
      limm_pend_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // program counter
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pc_r <= PC_RST;
    end else if (restart_in) begin
      pc_r <= restart_pc_in;
    end else if (hcnt_r != 2'd0 && !skip_r &&
                 (emit || (!part_v_r && cur_long))) begin
      pc_r <= pc_r + HALF_STEP;                             // RULE_04
    end
  end

  // -------------------------------------------------------------------
  // entry build toward the fifo
  // -------------------------------------------------------------------
  // only whole instructions leave, shorts zero-extended; field decode downstream never sees half of a long
  always_comb begin
    ent_if.valid = emit;
    ent_if.data  = '{word: '0, pc: '0, kind: MWIU_KIND_SHORT};
    if (part_v_r) begin
      ent_if.data.word = {part_r, cur_h};                   // RULE_13
      ent_if.data.pc   = part_pc_r;
      ent_if.data.kind = kind_limm_r ? MWIU_KIND_LIMM : MWIU_KIND_LONG;
    end else begin
      ent_if.data.word = {{HALF_W{1'b0}}, cur_h};
      ent_if.data.pc   = pc_r;
      ent_if.data.kind = MWIU_KIND_SHORT;
    end
  end

  mwiu_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_in       (clk_in),
    .srst_in      (srst_in || restart_in),
    .wr_valid_in  (ent_if.valid),
    .wr_ready_out (ent_if.ready),
    .wr_data_in   (ent_if.data),
    .rd_valid_out (fifo_rd_v),
    .rd_ready_in  (!out_v_r || instr_ready_in),
    .rd_data_out  (fifo_rd_d)
  );

  assign fifo_ent = mwiu_entry_s'(fifo_rd_d);

  // -------------------------------------------------------------------
  // output register: every output straight from a flop
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in || restart_in) begin
      out_v_r  <= 1'b0;
      out_w_r  <= '0;
      out_pc_r <= PC_RST;
      out_s_r  <= 1'b0;
      out_l_r  <= 1'b0;
    end else if (!out_v_r || instr_ready_in) begin
      out_v_r  <= fifo_rd_v;
      // empty fifo shows stale storage, so data loads only on valid
      if (fifo_rd_v) begin
        out_w_r  <= fifo_ent.word;
        out_pc_r <= fifo_ent.pc;
        out_s_r  <= (fifo_ent.kind == MWIU_KIND_SHORT);
        out_l_r  <= (fifo_ent.kind == MWIU_KIND_LIMM);
      end
    end
  end

  assign instr_valid_out = out_v_r;
  assign instr_word_out  = out_w_r;
  assign instr_pc_out    = out_pc_r;
  assign instr_short_out = out_s_r;
  assign instr_limm_out  = out_l_r;
endmodule : mwiu_unpacker

// file: mwiu_pkg.sv
package mwiu_pkg;
  // ---------------------------------------------------------------------
  // widths and layout
  // ---------------------------------------------------------------------
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned HALF_W      = 16;
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned FIFO_AW     = 4;
  // halfword step and word step in bytes
  localparam logic [31:0] HALF_STEP   = 32'h0000_0002;
  localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
  // reset values
  localparam logic [31:0] PC_RST      = 32'h0000_0000;
  localparam logic        BIG_END_RST = 1'b0;
  // major opcode field sits in bits 15:11 of the first halfword
  localparam int unsigned OPC_MSB     = 15;
  localparam int unsigned OPC_LSB     = 11;
  // major opcodes below this value are 32-bit formats
  localparam logic [4:0]  OPC_SHORT_MIN = 5'h0c;

  // how an instruction is being built
  typedef enum logic [1:0] {
    MWIU_KIND_SHORT,
    MWIU_KIND_LONG,
    MWIU_KIND_LIMM
  } mwiu_kind_e;

  // one unpacked output entry
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [ADDR_W-1:0] pc;
    mwiu_kind_e        kind;
  } mwiu_entry_s;

  localparam int unsigned ENTRY_W = $bits(mwiu_entry_s);
endpackage : mwiu_pkg

// file: mwiu_stream_if.sv
`timescale 1ns/100ps
// valid/ready stream of unpacked entries between unpacker and fifo
interface mwiu_stream_if;
  import mwiu_pkg::*;
  logic        valid;
  logic        ready;
  mwiu_entry_s data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : mwiu_stream_if

// file: mwiu_fifo.sv
`timescale 1ns/100ps
module mwiu_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // -------------------------------------------------------------------
  // handshake
  // -------------------------------------------------------------------
  assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_r != '0);
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;
  assign rd_data_out  = mem_r[rp_r];

  // storage, no reset needed on data
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wp_r] <= wr_data_in;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= rp_r + AW'(1);
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_r <= cnt_r - (AW+1)'(1);
      end
    end
  end
endmodule : mwiu_fifo

// file: mwiu_unpacker_checker.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// port checker for the unpacker
// ---------------------------------------------------------------
module mwiu_unpacker_checker (
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic        big_endian_in,
  input wire logic        restart_in,
  input wire logic [31:0] restart_pc_in,
  input wire logic        limm_follows_in,
  input wire logic        fetch_valid_in,
  input wire logic        fetch_ready_out,
  input wire logic [31:0] fetch_word_in,
  input wire logic        instr_valid_out,
  input wire logic        instr_ready_in,
  input wire logic [31:0] instr_word_out,
  input wire logic [31:0] instr_pc_out,
  input wire logic        instr_short_out,
  input wire logic        instr_limm_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic        seen_r;
  logic        prev_r;
  logic [31:0] npc_r;
  sequence s_take;
    fetch_valid_in && fetch_ready_out && !restart_in;
  endsequence
  sequence s_emit;
    instr_valid_out && instr_ready_in;
  endsequence
  // restart seen since reset: fetch must wait for it
  always_ff @(posedge clk_in) begin
    seen_r <= !srst_in && (seen_r || restart_in);
  end
  // pc that the next entry must carry; a restart breaks the chain
  always_ff @(posedge clk_in) begin
    prev_r <= !srst_in && !restart_in &&
              (prev_r || (instr_valid_out && instr_ready_in));
    if (instr_valid_out && instr_ready_in) begin
      npc_r <= instr_pc_out + (instr_short_out ? 32'h2 : 32'h4);
    end
  end
  a_idle_before_start: assert property (!seen_r
    |-> !fetch_ready_out) else $error("fetch ready before any restart");
  a_ready_after_restart: assert property (restart_in
    |=> fetch_ready_out) else $error("no fetch ready after restart");
  a_restart_flush: assert property (restart_in |=> !instr_valid_out)
    else $error("output survived a restart");
  a_half_held: assert property (s_take |=> !fetch_ready_out)
    else $error("fetch taken while a half is held");
  a_out_stable: assert property (instr_valid_out && !instr_ready_in
    && !restart_in |=> instr_valid_out && $stable(instr_word_out)
    && $stable(instr_pc_out)) else $error("entry changed before taken");
  a_next_pc: assert property (instr_valid_out && prev_r
    |-> instr_pc_out == npc_r) else $error("pc step wrong");
  a_long_opcode: assert property (instr_valid_out
    && !instr_short_out && !instr_limm_out
    |-> instr_word_out[31:27] < 5'h0c)
    else $error("long entry has short opcode");
  a_short_opcode: assert property (instr_valid_out
    && instr_short_out |-> instr_word_out[15:11] >= 5'h0c)
    else $error("short opcode wrong");
  a_pc_even: assert property (s_emit |-> !instr_pc_out[0])
    else $error("entry pc not on a halfword");
  a_limm_long: assert property (instr_valid_out && instr_limm_out
    |-> !instr_short_out) else $error("limm marked short");
endmodule : mwiu_unpacker_checker

// file: mwiu_mem_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// instruction memory: words in address order, prompt or slow
// ---------------------------------------------------------------
module mwiu_mem_model (
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic        restart_in,
  input wire logic [31:0] restart_pc_in,
  input wire logic        fetch_ready_in,
  input wire logic        slow_in,
  output logic            fetch_valid_out,
  output logic     [31:0] fetch_word_out
);
  logic [7:0]  mem [1024] = '{default: 8'h00};  // prefetch past code
  logic [31:0] addr_r;
  logic [31:0] last_r;
  logic [1:0]  gap_r;
  logic [9:0]  a;
  assign a = addr_r[9:0];
  // idle bus shows the inverse of the last word, never a stale copy
  always_comb begin
    fetch_word_out = fetch_valid_out ? {mem[a + 10'd3], mem[a + 10'd2],
      mem[a + 10'd1], mem[a]} : ~last_r;
  end
  // valid is held until taken; slow mode offers one word in four
  always_ff @(posedge clk_in) begin
    gap_r <= gap_r + 2'd1;
    if (srst_in) begin
      fetch_valid_out <= 1'b0;
      gap_r <= 2'd0;
      addr_r <= 32'h0;
      last_r <= 32'h0;
    end else if (restart_in) begin
      fetch_valid_out <= 1'b1;
      addr_r <= {restart_pc_in[31:2], 2'b00};
    end else begin
      if (fetch_valid_out && fetch_ready_in) begin
        addr_r <= addr_r + 32'h4;
        last_r <= fetch_word_out;
      end
      if (!fetch_valid_out || fetch_ready_in) begin
        fetch_valid_out <= !slow_in || gap_r == 2'd0;
      end
    end
  end
endmodule : mwiu_mem_model

// file: mwiu_unpacker_tb.sv
`timescale 1ns/100ps
module mwiu_unpacker_tb;
  import mwiu_pkg::*;
  logic        clk_in = 0, srst_in = 1, big_endian_in = 0, restart_in = 0;
  logic        limm_follows_in = 0, instr_ready_in = 0, slow = 0, hold = 1;
  logic [31:0] restart_pc_in = 0, xs = 32'd53;
  logic        fetch_valid_in, fetch_ready_out, instr_valid_out;
  logic        instr_short_out, instr_limm_out;
  logic [31:0] fetch_word_in, instr_word_out, instr_pc_out;
  logic [65:0] exp_q[$];
  logic [65:0] e, got;
  int          fail_count = 0, n_checks = 0, cyc = 0;
  always #12.5 clk_in = ~clk_in;
  mwiu_unpacker i_dut (.*);
  mwiu_mem_model i_mem (.clk_in(clk_in), .srst_in(srst_in),
    .restart_in(restart_in), .restart_pc_in(restart_pc_in),
    .fetch_ready_in(fetch_ready_out), .slow_in(slow),
    .fetch_valid_out(fetch_valid_in), .fetch_word_out(fetch_word_in));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs;
  endfunction : rnd
  task automatic check(input logic [65:0] seen, input logic [65:0] want);
    n_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // one halfword into memory in the byte order of the build
  task automatic put16(input int a, input logic [15:0] h, input bit be);
    int lo, hi;
    lo = a % 1024;
    hi = (a + 1) % 1024;
    if (be) {i_mem.mem[lo], i_mem.mem[hi]} = h;
    else {i_mem.mem[hi], i_mem.mem[lo]} = h;
  endtask : put16
  // load a random mix, restart, then drain or abort midway
  task automatic run(input bit be, input bit lim, input int pc,
                     input int n, input bit abort);
    logic [31:0] w;
    int          a;
    hold = 1;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    exp_q.delete();
    a = pc;
    for (int i = 0; i < n; i++) begin
      w = rnd();
      if (!(i == 0 && lim) && w[0]) begin
        w[15:11] = 5'h0c + 5'(w[20:16] % 5'd20);
        put16(a, w[15:0], be);
        exp_q.push_back({2'b01, 32'(a), 16'h0000, w[15:0]});
        a += 2;
      end else begin
        if (!(i == 0 && lim)) w[31:27] = w[26:22] % 5'd12;
        put16(a, w[31:16], be);
        put16(a + 2, w[15:0], be);
        exp_q.push_back({lim && i == 0, 1'b0, 32'(a), w});
        a += 4;
      end
    end
    @(posedge clk_in);
    restart_in <= 1;
    restart_pc_in <= 32'(pc);
    big_endian_in <= be;
    @(posedge clk_in);
    restart_in <= 0;
    // stale entries of the last run are flushed only by this edge
    hold = 0;
    limm_follows_in <= lim;
    @(posedge clk_in);
    limm_follows_in <= 0;
    if (abort) repeat (25) @(posedge clk_in);
    else wait (exp_q.size() == 0);
  endtask : run
  // ---------------------------------------------------------------
  // model compare at every accepted entry, random backpressure
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    if (instr_valid_out && instr_ready_in) begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : '1;
      got = {instr_limm_out, instr_short_out, instr_pc_out, instr_word_out};
      check(got, e);
    end
    instr_ready_in <= !hold && exp_q.size() != 0 && rnd() % 4 != 0;
  end
  // hang guard: a few thousand cycles cover all tests
  always @(posedge clk_in) begin
    if (++cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge clk_in);
    srst_in <= 0;
    for (int t = 0; t < 8; t++) begin
      slow <= t[1];
      run(t[0], t[2], t * 128 + t[1] * 2, 40, t == 3);
      $display("test %0d done, %0d checks", t, n_checks);
    end
    complete_run();
  end
endmodule : mwiu_unpacker_tb
bind mwiu_unpacker mwiu_unpacker_checker i_chk (.*);
